// file: ebl_pkg.sv
// Constants, types and helper functions shared by the load decoder design.
package ebl_pkg;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] REL_BIAS = 16'h0002;
    localparam logic [15:0] LONG_LEN = 16'h0003;
    localparam logic [7:0] PFX_FIRST = 8'hDD;
    localparam logic [7:0] PFX_SECOND = 8'hFD;
    localparam logic [7:0] OP_HALT = 8'h76;
    localparam logic [7:0] OP_LOAD_A_BCI = 8'h0A;
    localparam logic [7:0] OP_LOAD_A_DEI = 8'h1A;
    localparam logic [7:0] OP_ST_BCI = 8'h02;
    localparam logic [7:0] OP_ST_DEI = 8'h12;
    localparam logic [7:0] OP_LOAD_A_EXT = 8'h3A;
    localparam logic [7:0] OP_ST_EXT = 8'h32;
    localparam logic [7:0] OP_ST_HLI_IMM = 8'h36;
    localparam logic [2:0] R_B = 3'h0;
    localparam logic [2:0] R_C = 3'h1;
    localparam logic [2:0] R_D = 3'h2;
    localparam logic [2:0] R_E = 3'h3;
    localparam logic [2:0] R_H = 3'h4;
    localparam logic [2:0] R_L = 3'h5;
    localparam logic [2:0] R_MEM = 3'h6;
    localparam logic [2:0] R_A = 3'h7;
    localparam int FLAG_S = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_P = 2;
    localparam int FLAG_C = 0;

    typedef enum logic [2:0] {
        K_NONE, K_REG, K_IMM, K_HLI, K_BCI, K_DEI, K_IDX, K_EXT
    } ebl_kind_t;

    typedef enum logic [2:0] {
        PR_GEN2, PR_GEN3, PR_PTR, PR_ACCF, PR_STK, PR_IDX1, PR_IDX2
    } ebl_pair_t;

    typedef enum logic [8:0] {
        ST_FETCH = 9'h001,
        ST_DECODE = 9'h002,
        ST_DISP = 9'h004,
        ST_IMM = 9'h008,
        ST_ADLO = 9'h010,
        ST_ADHI = 9'h020,
        ST_MEMRD = 9'h040,
        ST_MEMWR = 9'h080,
        ST_EXEC = 9'h100
    } ebl_state_t;

    function automatic logic [15:0] sext8(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction

    function automatic logic general_src(input ebl_kind_t k);
        return (k == K_REG) || (k == K_IMM) || (k == K_HLI) || (k == K_IDX);
    endfunction

    function automatic logic modify_ok(input ebl_kind_t k);
        return (k == K_REG) || (k == K_HLI) || (k == K_IDX);
    endfunction
endpackage

// file: ebl_dec_if.sv
// Decode bundle between the load decoder and the sequencing core.
`timescale 1ns/1ns
interface ebl_dec_if;
    import ebl_pkg::*;
    logic [7:0] opcode;
    logic pfx_active;
    logic valid;
    ebl_kind_t dst_kind;
    ebl_kind_t src_kind;
    logic [2:0] dst_reg;
    logic [2:0] src_reg;
    logic need_disp;
    logic need_imm;
    logic need_addr;
    modport decoder(input opcode, pfx_active, output valid, dst_kind, src_kind,
        dst_reg, src_reg, need_disp, need_imm, need_addr);
    modport core(output opcode, pfx_active, input valid, dst_kind, src_kind,
        dst_reg, src_reg, need_disp, need_imm, need_addr);
endinterface

// file: ebl_decoder.sv
// Combinational decoder for the 8-bit load opcode group.
`timescale 1ns/1ns
module ebl_decoder
    import ebl_pkg::*;
(
    ebl_dec_if.decoder dif
);
    ebl_kind_t mem_kind;
    logic [7:0] op;

    assign op = dif.opcode;
    assign mem_kind = dif.pfx_active ? K_IDX : K_HLI;

    always_comb begin
        dif.dst_kind = K_NONE;
        dif.src_kind = K_NONE;
        dif.dst_reg = op[5:3];
        dif.src_reg = op[2:0];
        dif.need_imm = 1'b0;
        dif.need_addr = 1'b0;
        if (op[7:6] == 2'b01 && op != OP_HALT) begin
            dif.dst_kind = (op[5:3] == R_MEM) ? mem_kind : K_REG;
            dif.src_kind = (op[2:0] == R_MEM) ? mem_kind : K_REG;
        end else if (op[7:6] == 2'b00 && op[2:0] == R_MEM) begin
            dif.dst_kind = (op[5:3] == R_MEM) ? mem_kind : K_REG;
            dif.src_kind = K_IMM;
            dif.need_imm = 1'b1;
        end else if (op == OP_LOAD_A_BCI) begin
            dif.dst_kind = K_REG;
            dif.dst_reg = R_A;
            dif.src_kind = K_BCI;
        end else if (op == OP_LOAD_A_DEI) begin
            dif.dst_kind = K_REG;
            dif.dst_reg = R_A;
            dif.src_kind = K_DEI;
        end else if (op == OP_ST_BCI || op == OP_ST_DEI) begin
            dif.dst_kind = (op == OP_ST_BCI) ? K_BCI : K_DEI;
            dif.src_kind = K_REG;
            dif.src_reg = R_A;
        end else if (op == OP_LOAD_A_EXT || op == OP_ST_EXT) begin
            dif.dst_kind = (op == OP_ST_EXT) ? K_EXT : K_REG;
            dif.dst_reg = R_A;
            dif.src_kind = (op == OP_ST_EXT) ? K_REG : K_EXT;
            dif.src_reg = R_A;
            dif.need_addr = 1'b1;
        end
    end

    assign dif.need_disp = (dif.dst_kind == K_IDX) || (dif.src_kind == K_IDX);
    // Pair-indirect and extended forms sit outside the general classes by design.
    assign dif.valid = (dif.src_kind != K_NONE) &&
        (general_src(dif.src_kind) || dif.src_kind inside {K_BCI, K_DEI, K_EXT}) &&
        (modify_ok(dif.dst_kind) || dif.dst_kind inside {K_BCI, K_DEI, K_EXT});
endmodule

// file: ebl_opclass.sv
// Operand class evaluation: conditions, register pairs, bit numbers, relative targets.
`timescale 1ns/1ns
module ebl_opclass
    import ebl_pkg::*;
(
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand,
    input wire logic [7:0] flags,
    input wire logic [15:0] instr_pc,
    output logic cond_met,
    output ebl_pair_t push_pop_pair,
    output ebl_pair_t arith_pair,
    output ebl_pair_t first_idx_pair,
    output ebl_pair_t second_idx_pair,
    output logic [2:0] bit_num,
    output logic [15:0] rel_target
);
    always_comb begin
        case (opcode[5:3])
            3'h0: cond_met = !flags[FLAG_Z];
            3'h1: cond_met = flags[FLAG_Z];
            3'h2: cond_met = !flags[FLAG_C];
            3'h3: cond_met = flags[FLAG_C];
            3'h4: cond_met = !flags[FLAG_P];
            3'h5: cond_met = flags[FLAG_P];
            3'h6: cond_met = !flags[FLAG_S];
            default: cond_met = flags[FLAG_S];
        endcase
    end

    always_comb begin
        case (opcode[5:4])
            2'h0: begin
                push_pop_pair = PR_GEN2;
                arith_pair = PR_GEN2;
                first_idx_pair = PR_GEN2;
                second_idx_pair = PR_GEN2;
            end
            2'h1: begin
                push_pop_pair = PR_GEN3;
                arith_pair = PR_GEN3;
                first_idx_pair = PR_GEN3;
                second_idx_pair = PR_GEN3;
            end
            2'h2: begin
                push_pop_pair = PR_PTR;
                arith_pair = PR_PTR;
                first_idx_pair = PR_IDX1;
                second_idx_pair = PR_IDX2;
            end
            default: begin
                push_pop_pair = PR_ACCF;
                arith_pair = PR_STK;
                first_idx_pair = PR_STK;
                second_idx_pair = PR_STK;
            end
        endcase
    end

    assign bit_num = opcode[5:3];
    assign rel_target = instr_pc + REL_BIAS + sext8(operand);
endmodule

// file: ebl_core.sv
// Functional notes
// - Register code picks one of A, B, C, D, E, H or L.
// - Pointer-indirect access uses the memory pointer pair as address.
// - Indexed address is index register plus sign-extended displacement.
// - Immediate bytes and 16-bit addresses are treated as unsigned.
// - Bit number field ranges 0 to 7, bit 7 most significant.
// - Relative target spans -126 to +129 from the jump opcode.
// - Eight flag conditions decoded for conditional jumps, calls and returns.
// - Push/pop pairs end with accumulator-flags; arithmetic pairs end with stack pointer.
// - First index-pair class uses the first index register; second uses the second.
// - General source accepts register, immediate, pointer or indexed; modify excludes immediate.
// - Opcode fetched in the opcode fetch cycle, decoded, transfer done.
// - Opcode 72 stores register D at the memory pointer address.
// - Accumulator loads from A, B..L decode from 7F and 78 to 7D.
// - Accumulator loads from memory decode as 7E, 0A and 1A.
// - Register loads into B, C, D use rows at 40, 48, 50.
// - Stores of B..L to pointer address decode 70 to 75, A 77.
// - Displacement byte follows the opcode, before any immediate byte.
// - Two-byte address arrives low byte first, then high byte.
// - Indexed loads occupy three bytes, the third being the displacement.
`timescale 1ns/1ns
module ebl_core
    import ebl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ready,
    input wire logic [7:0] flags_in,
    input wire logic [15:0] index_first,
    input wire logic [15:0] index_second,
    output logic mem_rd_r,
    output logic mem_wr_r,
    output logic [15:0] mem_addr_r,
    output logic [7:0] mem_wdata_r,
    output logic opcode_fetch_cycle_r,
    output logic [15:0] pc_r,
    output logic [63:0] gpr_view,
    output logic instr_done_r,
    output logic illegal_op_r,
    output logic cond_met_r,
    output ebl_pair_t push_pop_pair_r,
    output ebl_pair_t arith_pair_r,
    output ebl_pair_t first_idx_pair_r,
    output ebl_pair_t second_idx_pair_r,
    output logic [2:0] bit_num_r,
    output logic [15:0] rel_target_r
);
    ebl_state_t state_r;
    ebl_state_t state_nxt;
    logic [7:0] regs_r [0:7];
    logic [7:0] op_r;
    logic [7:0] data_r;
    logic [7:0] disp_r;
    logic disp_done_r;
    logic pfx_active_r;
    logic pfx_second_r;
    logic [15:0] ea_r;
    logic [15:0] ea_nxt;
    logic [15:0] pc_nxt;
    logic [15:0] instr_pc_r;
    logic xfer;
    logic src_mem;
    logic dst_mem;
    logic [15:0] idx_base;
    logic [7:0] wdata_nxt;
    logic cond_met;
    ebl_pair_t push_sel;
    ebl_pair_t arith_sel;
    ebl_pair_t idx1_sel;
    ebl_pair_t idx2_sel;
    logic [2:0] bit_num;
    logic [15:0] rel_target;

    ebl_dec_if dif();

    assign dif.opcode = op_r;
    assign dif.pfx_active = pfx_active_r;

    ebl_decoder u_decoder (
        .dif(dif)
    );

    ebl_opclass u_opclass (
        .opcode(op_r),
        .operand(data_r),
        .flags(regs_r[R_MEM]),
        .instr_pc(instr_pc_r),
        .cond_met(cond_met),
        .push_pop_pair(push_sel),
        .arith_pair(arith_sel),
        .first_idx_pair(idx1_sel),
        .second_idx_pair(idx2_sel),
        .bit_num(bit_num),
        .rel_target(rel_target)
    );

    function automatic logic is_pfx(input logic [7:0] b);
        return (b == PFX_FIRST) || (b == PFX_SECOND);
    endfunction

    function automatic logic pc_state(input ebl_state_t s);
        return s inside {ST_FETCH, ST_DISP, ST_IMM, ST_ADLO, ST_ADHI};
    endfunction

    // Picks the next phase; operand bytes always come in displacement, data, address order.
    function automatic ebl_state_t next_step(input logic disp_todo, input logic imm_todo,
        input logic addr_todo, input logic rd_todo, input logic wr_todo);
        if (disp_todo) begin
            return ST_DISP;
        end else if (imm_todo) begin
            return ST_IMM;
        end else if (addr_todo) begin
            return ST_ADLO;
        end else if (rd_todo) begin
            return ST_MEMRD;
        end else if (wr_todo) begin
            return ST_MEMWR;
        end
        return ST_EXEC;
    endfunction

    assign xfer = mem_ready && (mem_rd_r || mem_wr_r);
    assign src_mem = dif.src_kind inside {K_HLI, K_BCI, K_DEI, K_IDX, K_EXT};
    assign dst_mem = dif.dst_kind inside {K_HLI, K_BCI, K_DEI, K_IDX, K_EXT};
    assign idx_base = pfx_second_r ? index_second : index_first;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_FETCH: begin
                if (xfer) begin
                    state_nxt = is_pfx(mem_rdata) ? ST_FETCH : ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (!dif.valid) begin
                    state_nxt = ST_FETCH;
                end else begin
                    state_nxt = next_step(dif.need_disp, dif.need_imm, dif.need_addr,
                        src_mem, dst_mem);
                end
            end
            ST_DISP: begin
                if (xfer) begin
                    state_nxt = next_step(1'b0, dif.need_imm, 1'b0, src_mem, dst_mem);
                end
            end
            ST_IMM: begin
                if (xfer) begin
                    state_nxt = next_step(1'b0, 1'b0, 1'b0, 1'b0, dst_mem);
                end
            end
            ST_ADLO: begin
                if (xfer) begin
                    state_nxt = ST_ADHI;
                end
            end
            ST_ADHI: begin
                if (xfer) begin
                    state_nxt = next_step(1'b0, 1'b0, 1'b0, src_mem, dst_mem);
                end
            end
            ST_MEMRD: begin
                if (xfer) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_MEMWR: begin
                if (xfer) begin
                    state_nxt = ST_FETCH;
                end
            end
            ST_EXEC: begin
                state_nxt = ST_FETCH;
            end
            default: begin
                state_nxt = ST_FETCH;
            end
        endcase
    end

    always_comb begin
        pc_nxt = pc_r;
        if (xfer && pc_state(state_r)) begin
            pc_nxt = pc_r + PC_STEP;
        end
    end

    always_comb begin
        ea_nxt = ea_r;
        if (state_r == ST_DECODE) begin
            if (dif.src_kind == K_HLI || dif.dst_kind == K_HLI) begin
                ea_nxt = {regs_r[R_H], regs_r[R_L]};
            end else if (dif.src_kind == K_BCI || dif.dst_kind == K_BCI) begin
                ea_nxt = {regs_r[R_B], regs_r[R_C]};
            end else if (dif.src_kind == K_DEI || dif.dst_kind == K_DEI) begin
                ea_nxt = {regs_r[R_D], regs_r[R_E]};
            end
        end else if (state_r == ST_DISP && xfer) begin
            ea_nxt = idx_base + sext8(mem_rdata);
        end else if (state_r == ST_ADLO && xfer) begin
            ea_nxt = {ea_r[15:8], mem_rdata};
        end else if (state_r == ST_ADHI && xfer) begin
            ea_nxt = {mem_rdata, ea_r[7:0]};
        end
    end

    always_comb begin
        if (state_r == ST_IMM) begin
            wdata_nxt = mem_rdata;
        end else begin
            wdata_nxt = regs_r[dif.src_reg];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_FETCH;
            pc_r <= PC_RESET;
            ea_r <= PC_RESET;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            ea_r <= ea_nxt;
        end
    end

    // Bus requests are registered from the next state so they lead each phase.
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_rd_r <= 1'b1;
            mem_wr_r <= 1'b0;
            mem_addr_r <= PC_RESET;
            mem_wdata_r <= REG_RESET;
            opcode_fetch_cycle_r <= 1'b1;
        end else begin
            mem_rd_r <= pc_state(state_nxt) || (state_nxt == ST_MEMRD);
            mem_wr_r <= (state_nxt == ST_MEMWR);
            mem_addr_r <= (state_nxt inside {ST_MEMRD, ST_MEMWR}) ? ea_nxt : pc_nxt;
            opcode_fetch_cycle_r <= (state_nxt == ST_FETCH);
            if (state_nxt == ST_MEMWR && state_r != ST_MEMWR) begin
                mem_wdata_r <= wdata_nxt;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            op_r <= REG_RESET;
            pfx_active_r <= 1'b0;
            pfx_second_r <= 1'b0;
            instr_pc_r <= PC_RESET;
        end else begin
            if (state_r == ST_FETCH && xfer) begin
                if (is_pfx(mem_rdata)) begin
                    pfx_active_r <= 1'b1;
                    pfx_second_r <= (mem_rdata == PFX_SECOND);
                end else begin
                    op_r <= mem_rdata;
                end
            end else if (state_nxt == ST_FETCH && state_r != ST_FETCH) begin
                pfx_active_r <= 1'b0;
                pfx_second_r <= 1'b0;
                instr_pc_r <= pc_nxt;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_r <= REG_RESET;
            disp_r <= REG_RESET;
            disp_done_r <= 1'b0;
        end else begin
            if (state_r == ST_DISP && xfer) begin
                disp_r <= mem_rdata;
                disp_done_r <= 1'b1;
            end else if (state_r == ST_FETCH) begin
                disp_done_r <= 1'b0;
            end
            if ((state_r == ST_IMM || state_r == ST_MEMRD) && xfer) begin
                data_r <= mem_rdata;
            end
        end
    end

    // Slot R_MEM of the register file holds the flag byte from the arithmetic side.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                regs_r[i] <= REG_RESET;
            end
        end else begin
            regs_r[R_MEM] <= flags_in;
            if (state_r == ST_EXEC && dif.dst_reg != R_MEM) begin
                if (dif.src_kind == K_REG) begin
                    regs_r[dif.dst_reg] <= regs_r[dif.src_reg];
                end else begin
                    regs_r[dif.dst_reg] <= data_r;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            instr_done_r <= 1'b0;
            illegal_op_r <= 1'b0;
        end else begin
            instr_done_r <= (state_r == ST_EXEC) || (state_r == ST_MEMWR && xfer);
            illegal_op_r <= (state_r == ST_DECODE) && !dif.valid;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cond_met_r <= 1'b0;
            push_pop_pair_r <= PR_GEN2;
            arith_pair_r <= PR_GEN2;
            first_idx_pair_r <= PR_GEN2;
            second_idx_pair_r <= PR_GEN2;
            bit_num_r <= 3'h0;
            rel_target_r <= PC_RESET;
        end else begin
            cond_met_r <= cond_met;
            push_pop_pair_r <= push_sel;
            arith_pair_r <= arith_sel;
            first_idx_pair_r <= idx1_sel;
            second_idx_pair_r <= idx2_sel;
            bit_num_r <= bit_num;
            rel_target_r <= rel_target;
        end
    end

    assign gpr_view = {regs_r[7], regs_r[6], regs_r[5], regs_r[4],
        regs_r[3], regs_r[2], regs_r[1], regs_r[0]};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_FETCH_AT_PC: assert property (
        opcode_fetch_cycle_r |-> mem_rd_r && !mem_wr_r && mem_addr_r == pc_r)
        else $error("opcode fetch not at program counter");
    AST_B_TO_C: assert property (
        (state_r == ST_EXEC && op_r == 8'h48) |=> regs_r[R_C] == $past(regs_r[R_B]))
        else $error("48 did not copy B into C");
    AST_HL_STORE_D: assert property (
        (state_r == ST_MEMWR && op_r == 8'h72 && !pfx_active_r) |->
        mem_wr_r && mem_addr_r == {regs_r[R_H], regs_r[R_L]} && mem_wdata_r == regs_r[R_D])
        else $error("72 store wrong address or data");
    AST_IDX_ADDR: assert property (
        (state_r inside {ST_MEMRD, ST_MEMWR} && pfx_active_r && dif.need_disp) |->
        mem_addr_r == idx_base + sext8(disp_r))
        else $error("indexed address wrong");
    AST_DISP_FIRST: assert property (
        (state_r == ST_IMM && dif.need_disp) |-> disp_done_r)
        else $error("immediate fetched before displacement");
    AST_ADDR_LOW_FIRST: assert property (
        (state_r == ST_ADLO && xfer) |=> ##1 ea_r[7:0] == $past(mem_rdata, 2))
        else $error("first address byte not low half");
    AST_IDX_LENGTH: assert property (
        (state_r inside {ST_MEMRD, ST_MEMWR} && dif.need_disp && !dif.need_imm) |->
        pc_r == instr_pc_r + LONG_LEN)
        else $error("indexed load not three bytes");
    AST_EXT_LENGTH: assert property (
        (state_r inside {ST_MEMRD, ST_MEMWR} && dif.need_addr) |->
        pc_r == instr_pc_r + LONG_LEN)
        else $error("direct address load not three bytes");
    AST_PAIR_SOURCE: assert property (
        (state_r == ST_MEMRD && op_r == OP_LOAD_A_BCI) |->
        mem_addr_r == {regs_r[R_B], regs_r[R_C]})
        else $error("0A not addressed by the B-C pair");
    AST_MEM_TO_A: assert property (
        (state_r == ST_MEMRD && xfer && op_r == 8'h7E) |-> ##2 regs_r[R_A] == $past(mem_rdata, 2))
        else $error("memory byte not loaded into A");

    COV_INDEXED_IMM: cover property (state_r == ST_MEMWR && pfx_active_r && dif.need_imm);
    COV_EXT_LOAD: cover property (state_r == ST_EXEC && op_r == OP_LOAD_A_EXT);
    COV_ILLEGAL: cover property (illegal_op_r);
endmodule

// file: ebl_mem_model.sv
// Program memory model that answers the core's read and write requests.
`timescale 1ns/1ns
module ebl_mem_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic mem_rd_r,
    input wire logic mem_wr_r,
    input wire logic [15:0] mem_addr_r,
    input wire logic [7:0] mem_wdata_r,
    output logic [7:0] mem_rdata,
    output logic mem_ready
);
    logic [7:0] mem [0:65535];
    logic done_r = 1'b0;
    logic tick_r = 1'b0;
    logic [7:0] last_r = 8'h00;
    initial begin
        mem_ready = 1'b0;
        mem_rdata = 8'h00;
    end
    always @(posedge clk) begin
        done_r <= mem_ready && (mem_rd_r || mem_wr_r);
        if (mem_ready && mem_wr_r) begin
            mem[mem_addr_r] <= mem_wdata_r;
        end
    end
    // Outside an answer the data lines carry the inverse of the last byte sent.
    always @(negedge clk) begin
        tick_r <= !tick_r;
        if ((mem_rd_r || mem_wr_r) && !done_r && (!slow || tick_r)) begin
            mem_ready <= 1'b1;
            mem_rdata <= mem_rd_r ? mem[mem_addr_r] : ~last_r;
            if (mem_rd_r) begin
                last_r <= mem[mem_addr_r];
            end
        end else begin
            mem_ready <= 1'b0;
            mem_rdata <= ~last_r;
        end
    end
endmodule

// file: eight_bit_load_decoder_tb.sv
// Self-checking testbench for the load decoder core.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("wrong value %s exp %h got %h", nm, e, g); num_errors++; end end
module eight_bit_load_decoder_tb
    import ebl_pkg::*;
;
    typedef struct {logic [31:0] b; int len; logic [15:0] sel; logic [7:0] exp;} ebl_row_t;
    logic clk, reset, slow, mem_rd_r, mem_wr_r, mem_ready, opcode_fetch_cycle_r;
    logic instr_done_r, illegal_op_r, cond_met_r;
    logic [7:0] mem_rdata, mem_wdata_r, got;
    logic [7:0] flags_in = 8'h40;
    logic [15:0] mem_addr_r;
    logic [15:0] index_first = 16'h0200;
    logic [15:0] index_second = 16'h0300;
    logic [63:0] gpr_view;
    logic [2:0] bit_num_r;
    ebl_pair_t push_pop_pair_r;
    ebl_pair_t arith_pair_r, first_idx_pair_r, second_idx_pair_r;
    logic [15:0] pc_r, rel_target_r;
    int num_errors = 0;
    int n_tests = 0;
    // Bytes are listed first byte in the top bits; sel below 8 picks a register.
    ebl_row_t rows [20] = '{
        '{32'h06110000, 2, 16'h0000, 8'h11},
        '{32'h0E220000, 2, 16'h0001, 8'h22},
        '{32'h16330000, 2, 16'h0002, 8'h33},
        '{32'h1E440000, 2, 16'h0003, 8'h44},
        '{32'h26010000, 2, 16'h0004, 8'h01},
        '{32'h2E000000, 2, 16'h0005, 8'h00},
        '{32'h3E770000, 2, 16'h0007, 8'h77},
        '{32'h48000000, 1, 16'h0001, 8'h11},
        '{32'h72000000, 1, 16'h0100, 8'h33},
        '{32'h7E000000, 1, 16'h0007, 8'h33},
        '{32'h7B000000, 1, 16'h0007, 8'h44},
        '{32'h77000000, 1, 16'h0100, 8'h44},
        '{32'hDD70FE00, 3, 16'h01FE, 8'h11},
        '{32'hFD360199, 4, 16'h0301, 8'h99},
        '{32'h32000400, 3, 16'h0400, 8'h44},
        '{32'h3A010300, 3, 16'h0007, 8'h99},
        '{32'h02000000, 1, 16'h1111, 8'h99},
        '{32'h1A000000, 1, 16'h0007, 8'h5A},
        '{32'hDD7EFE00, 3, 16'h0007, 8'h11},
        '{32'h12000000, 1, 16'h3344, 8'h11}
    };
    ebl_core i_dut (.clk, .reset, .mem_rdata, .mem_ready, .flags_in, .index_first,
        .index_second, .mem_rd_r, .mem_wr_r, .mem_addr_r, .mem_wdata_r,
        .opcode_fetch_cycle_r, .pc_r, .gpr_view, .instr_done_r, .illegal_op_r,
        .cond_met_r, .push_pop_pair_r, .arith_pair_r, .first_idx_pair_r,
        .second_idx_pair_r, .bit_num_r, .rel_target_r);
    ebl_mem_model i_mem (.clk, .slow, .mem_rd_r, .mem_wr_r, .mem_addr_r, .mem_wdata_r,
        .mem_rdata, .mem_ready);
    task automatic finish_test();
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wait_for(input int which);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while ((which ? illegal_op_r : instr_done_r) !== 1'b1 && k < 40);
        if (k >= 40) begin
            num_errors++;
            finish_test();
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        int i, j, p;
        reset = 1'b1;
        slow = 1'b0;
        p = 0;
        for (i = 0; i < 65536; i++) i_mem.mem[i] = 8'h00;
        for (i = 0; i < 20; i++) begin
            for (j = 0; j < rows[i].len; j++) begin
                i_mem.mem[p] = rows[i].b[31 - 8 * j -: 8];
                p++;
            end
        end
        i_mem.mem[16'h3344] = 8'h5A;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        for (i = 0; i < 20; i++) begin
            slow = (i >= 10);
            wait_for(0);
            p = rows[i].sel;
            got = (p < 8) ? gpr_view[p * 8 +: 8] : i_mem.mem[p];
            `CHK("load result", rows[i].exp, got)
            if (i == 7) begin
                `CHK("bit number", 3'h1, bit_num_r)
                `CHK("push pair", PR_GEN2, push_pop_pair_r)
                `CHK("condition", 1'b1, cond_met_r)
                `CHK("relative target", 16'h0087, rel_target_r)
            end
            if (i == 4) begin
                `CHK("push pair", PR_PTR, push_pop_pair_r)
                `CHK("arith pair", PR_PTR, arith_pair_r)
                `CHK("first index pair", PR_IDX1, first_idx_pair_r)
                `CHK("second index pair", PR_IDX2, second_idx_pair_r)
            end
            if (i == 10) begin
                `CHK("push pair", PR_ACCF, push_pop_pair_r)
                `CHK("arith pair", PR_STK, arith_pair_r)
                `CHK("bit number", 3'h7, bit_num_r)
                `CHK("condition", 1'b0, cond_met_r)
            end
        end
        wait_for(1);
        `CHK("illegal done", 1'b0, instr_done_r)
        `CHK("program counter", 16'h0027, pc_r)
        @(negedge clk);
        `CHK("illegal pulse", 1'b0, illegal_op_r)
        reset = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("fetch request", 1'b1, mem_rd_r & opcode_fetch_cycle_r & ~mem_wr_r)
        `CHK("fetch address", 16'h0000, mem_addr_r)
        `CHK("registers", 64'h0000000000000000, gpr_view)
        reset = 1'b0;
        wait_for(0);
        `CHK("load after reset", 8'h11, gpr_view[7:0])
        finish_test();
    end
endmodule
